/* File: rtl/dss_scheduler.sv */
// daylight saving scheduler: schedule registers, calendar match, hour shift
//
// Summary of operation
// - bit 7 of start month register enables adjustment; off means no shift
// - first power-up clears the enable bit
// - writing the enable to zero clears the adjusted flag unless a forward shift sets it in the same cycle
// - start month uses clock month coding 1-12, resets to 00h
// - end month uses clock month coding 1-12, resets to 10h
// - start weekday priority set selects week and weekday matching
// - end weekday priority set selects week and weekday matching
// - start date matters only while start weekday priority is zero
// - end date matters only while end weekday priority is zero
// - low three bits of week/day registers hold weekday 0-6, reset zero
// - bits 3-5 hold week of month 1-5, code 7 means last week
// - date fields use clock date coding 1-31, reset zero
// - hour fields follow clock hour format without 24-hour select bit
// - start hour resets to zero
// - end hour resets to zero
`timescale 1ns/1ps
`default_nettype none
module dss_scheduler
    import dss_pkg::*;
(
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic clkEn,
    input wire dss_reg_req_t regReq,
    input wire logic flagWrEn,
    input wire logic flagWrData,
    input wire dss_cal_t cal,
    input wire logic secTick,
    output logic [7:0] rdData,
    output dss_hour_upd_t hourUpd,
    output logic daylightAdjusted
);
    logic [63:0] contents;
    logic inRange;
    logic [2:0] regIndex;
    logic bankWr;
    logic bankRd;
    dss_sched_t startSched;
    dss_sched_t endSched;
    logic daylightSavingEnable;
    logic enableClearWrite;
    logic [4:0] dateBin;
    logic [3:0] monthBin;
    logic [4:0] daysInMonth;
    logic [2:0] weekOfMonth;
    logic isLastWeek;
    logic topOfHour;
    logic startHit;
    logic endHit;
    logic doForward;
    logic doReverse;
    logic endArmed;
    logic next_endArmed;
    logic next_daylightAdjusted;
    logic hourIs24;
    logic [7:0] hourFwd;
    logic [7:0] hourRev;

    // address decode, only the eight schedule bytes are claimed
    assign inRange = (regReq.addr >= DSS_START_MONTH) && (regReq.addr <= DSS_END_HOUR);
    assign regIndex = regReq.addr[2:0];
    assign bankWr = regReq.wrEn && inRange;
    assign bankRd = regReq.rdEn && inRange;

    dss_reg_bank u_bank (
        .clk(clk),
        .sys_rst(sys_rst),
        .clkEn(clkEn),
        .wrEn(bankWr),
        .rdEn(bankRd),
        .index(regIndex),
        .wrData(regReq.data),
        .rdData(rdData),
        .contents(contents)
    );

    // unpack the bank into the two schedules
    assign startSched = {contents[8*0 +: 8], contents[8*1 +: 8],
                         contents[8*2 +: 8], contents[8*3 +: 8]};
    assign endSched = {contents[8*4 +: 8], contents[8*5 +: 8],
                       contents[8*6 +: 8], contents[8*7 +: 8]};
    assign daylightSavingEnable = startSched.month[DSS_ENABLE_BIT];
    assign enableClearWrite = bankWr && (regReq.addr == DSS_START_MONTH)
                              && !regReq.data[DSS_ENABLE_BIT];

    // calendar in binary for week arithmetic
    assign dateBin = (5'(cal.date[5:4]) * 5'd10) + {1'b0, cal.date[3:0]}; // tens need 5 bits
    assign monthBin = cal.month[4] ? (cal.month[3:0] + 4'd10) : cal.month[3:0];

    // month length needs the leap flag so the last week is right in february
    assign daysInMonth = (monthBin == 4'd2) ? (cal.leapYear ? 5'd29 : 5'd28) :
                         ((monthBin == 4'd4) || (monthBin == 4'd6) ||
                          (monthBin == 4'd9) || (monthBin == 4'd11)) ? 5'd30 : 5'd31;

    // week of month counts from the first, days 1-7 are week 1
    assign weekOfMonth = (dateBin <= 5'd7) ? 3'd1 :
                         (dateBin <= 5'd14) ? 3'd2 :
                         (dateBin <= 5'd21) ? 3'd3 :
                         (dateBin <= 5'd28) ? 3'd4 : 3'd5;
    // last week: no further same weekday fits in the month
    assign isLastWeek = ({1'b0, dateBin} + {1'b0, DSS_DAYS_IN_WEEK}) > {1'b0, daysInMonth};

    // changes happen on the tick that starts the scheduled hour
    assign topOfHour = secTick && (cal.minute == 8'h00) && (cal.second == 8'h00);

    // day selection by weekday priority or by date
    function automatic logic day_match(input dss_sched_t s, input dss_cal_t c,
                                       input logic [2:0] wk, input logic last);
        logic [2:0] sWeek;
        logic weekOk;
        sWeek = s.weekDay[DSS_WEEK_LSB +: 3];
        weekOk = (sWeek == DSS_LAST_WEEK) ? last : (sWeek == wk);
        if (s.weekDay[DSS_PRIO_BIT])
            day_match = weekOk && (s.weekDay[DSS_DOW_LSB +: 3] == c.dayOfWeek);
        else
            day_match = (s.date[5:0] == c.date[5:0]);
    endfunction

    // hour field carries no 24-hour select bit, compare the low six bits
    assign startHit = (startSched.month[4:0] == cal.month[4:0])
                      && day_match(startSched, cal, weekOfMonth, isLastWeek)
                      && (startSched.hour[5:0] == cal.hour[5:0]);
    assign endHit = (endSched.month[4:0] == cal.month[4:0])
                    && day_match(endSched, cal, weekOfMonth, isLastWeek)
                    && (endSched.hour[5:0] == cal.hour[5:0]);

    // the bank itself holds week and weekday, matching reads them here
    assign doForward = daylightSavingEnable && topOfHour && startHit;
    // reverse needs the arm so the repeated hour is left alone
    assign doReverse = daylightSavingEnable && topOfHour && endHit && endArmed
                       && !doForward;

    // the new hour follows the clock's own 12/24 mode
    assign hourIs24 = cal.hour[DSS_H24_BIT];

    function automatic logic [7:0] hour_inc(input logic [7:0] h);
        logic [7:0] r;
        r = h;
        if (h[DSS_H24_BIT])
        begin
            if (h[5:0] == 6'h23)
                r[5:0] = 6'h00;
            else if (h[3:0] == 4'h9)
                r[5:0] = {h[5:4] + 2'd1, 4'h0};
            else
                r[3:0] = h[3:0] + 4'd1;
        end
        else
        begin
            if (h[4:0] == 5'h11)
                r[5:0] = {~h[DSS_PM_BIT], 5'h12};
            else if (h[4:0] == 5'h12)
                r[4:0] = 5'h01;
            else if (h[3:0] == 4'h9)
                r[4:0] = 5'h10;
            else
                r[3:0] = h[3:0] + 4'd1;
        end
        hour_inc = r;
    endfunction

    function automatic logic [7:0] hour_dec(input logic [7:0] h);
        logic [7:0] r;
        r = h;
        if (h[DSS_H24_BIT])
        begin
            if (h[5:0] == 6'h00)
                r[5:0] = 6'h23;
            else if (h[3:0] == 4'h0)
                r[5:0] = {h[5:4] - 2'd1, 4'h9};
            else
                r[3:0] = h[3:0] - 4'd1;
        end
        else
        begin
            if (h[4:0] == 5'h12)
                r[5:0] = {~h[DSS_PM_BIT], 5'h11};
            else if (h[4:0] == 5'h01)
                r[4:0] = 5'h12;
            else if (h[4:0] == 5'h10)
                r[4:0] = 5'h09;
            else
                r[3:0] = h[3:0] - 4'd1;
        end
        hour_dec = r;
    endfunction

    // limitation: a shift across midnight does not carry into the date
    assign hourFwd = hour_inc(cal.hour);
    assign hourRev = hour_dec(cal.hour);

    // a forward shift wins over any clear arriving in the same cycle
    assign next_daylightAdjusted = doForward ? 1'b1 :
                                   doReverse ? 1'b0 :
                                   enableClearWrite ? 1'b0 :
                                   flagWrEn ? flagWrData : daylightAdjusted;

    // rearm only once the calendar leaves the end schedule again
    assign next_endArmed = doReverse ? 1'b0 :
                           (!endHit ? 1'b1 : endArmed);

    // flag and arm; enable is cleared by the bank reset on power-up
    always_ff @(posedge clk)
    begin
        if (sys_rst)
        begin
            daylightAdjusted <= 1'b0;
            endArmed <= 1'b1;
        end
        else if (clkEn)
        begin
            daylightAdjusted <= next_daylightAdjusted;
            endArmed <= next_endArmed;
        end
    end

    // one-cycle load of the corrected hour into the timekeeper
    always_ff @(posedge clk)
    begin
        if (sys_rst)
            hourUpd <= '0;
        else if (clkEn)
        begin
            hourUpd.load <= doForward || doReverse;
            hourUpd.value <= doForward ? hourFwd : (doReverse ? hourRev : hourUpd.value);
        end
    end

    // reset level one edge ago, for the power-up checks
    logic prevRst;
    always_ff @(posedge clk)
    begin
        prevRst <= sys_rst;
    end

    chk_enable_reset_clear: assert property (@(posedge clk)
        $fell(sys_rst) |-> !daylightSavingEnable && (endSched.month == DSS_RST_END_MONTH))
        else $error("enable or end month wrong after reset");

    chk_fields_reset_zero: assert property (@(posedge clk)
        prevRst && !sys_rst |-> startSched.hour == 8'h00 && endSched.hour == 8'h00
                                && startSched.date == 8'h00 && startSched.weekDay == 8'h00)
        else $error("schedule fields not zero after reset");

    chk_disabled_no_shift: assert property (@(posedge clk) disable iff (sys_rst)
        clkEn && !daylightSavingEnable |=> !hourUpd.load)
        else $error("hour shifted while disabled");

    chk_flag_cleared_off: assert property (@(posedge clk) disable iff (sys_rst)
        clkEn && enableClearWrite && !doForward |=> !daylightAdjusted)
        else $error("adjusted flag survived enable clear");

    chk_forward_sets_flag: assert property (@(posedge clk) disable iff (sys_rst)
        clkEn && doForward |=> daylightAdjusted && hourUpd.load && hourUpd.value == $past(hourFwd))
        else $error("forward shift incomplete");

    chk_reverse_clears_flag: assert property (@(posedge clk) disable iff (sys_rst)
        clkEn && doReverse |=> !daylightAdjusted && hourUpd.load
                               && hourUpd.value == $past(hourRev))
        else $error("reverse shift incomplete");

    chk_reverse_once: assert property (@(posedge clk) disable iff (sys_rst)
        clkEn && doReverse |=> !endArmed)
        else $error("reverse arm not dropped");

    chk_date_ignored_prio: assert property (@(posedge clk) disable iff (sys_rst)
        startSched.weekDay[DSS_PRIO_BIT] && startSched.month[4:0] == cal.month[4:0]
        && startSched.hour[5:0] == cal.hour[5:0]
        && startSched.weekDay[2:0] == cal.dayOfWeek
        && startSched.weekDay[5:3] == weekOfMonth |-> startHit)
        else $error("date used despite weekday priority");

    chk_last_week_hit: assert property (@(posedge clk) disable iff (sys_rst)
        isLastWeek == (dateBin > daysInMonth - 5'd7))
        else $error("last week not recognised");

    chk_load_pulse: assert property (@(posedge clk) disable iff (sys_rst)
        hourUpd.load && clkEn |=> !hourUpd.load)
        else $error("hour load longer than one cycle");

    cov_forward: cover property (@(posedge clk) disable iff (sys_rst) doForward);
    cov_reverse: cover property (@(posedge clk) disable iff (sys_rst) doReverse);
    cov_repeat_blocked: cover property (@(posedge clk) disable iff (sys_rst)
        topOfHour && endHit && !endArmed && daylightSavingEnable);
    cov_enable_clear: cover property (@(posedge clk) disable iff (sys_rst)
        enableClearWrite && daylightAdjusted);
endmodule
`default_nettype wire

/* File: pkg/dss_pkg.sv */
// constants, field layout and carrier types of the daylight saving scheduler
package dss_pkg;
    // register offsets
    localparam logic [7:0] DSS_START_MONTH = 8'h20;
    localparam logic [7:0] DSS_START_WEEK_DAY = 8'h21;
    localparam logic [7:0] DSS_START_DATE = 8'h22;
    localparam logic [7:0] DSS_START_HOUR = 8'h23;
    localparam logic [7:0] DSS_END_MONTH = 8'h24;
    localparam logic [7:0] DSS_END_WEEK_DAY = 8'h25;
    localparam logic [7:0] DSS_END_DATE = 8'h26;
    localparam logic [7:0] DSS_END_HOUR = 8'h27;
    localparam int DSS_NUM_REGS = 8;
    // reset values
    localparam logic [7:0] DSS_RST_ZERO = 8'h00;
    localparam logic [7:0] DSS_RST_END_MONTH = 8'h10;
    // writable bits per register, index 0 is the start month
    localparam logic [63:0] DSS_WR_MASK = {8'h3f, 8'h3f, 8'h7f, 8'h1f,
                                           8'h3f, 8'h3f, 8'h7f, 8'h9f};
    // field positions
    localparam int DSS_ENABLE_BIT = 7;
    localparam int DSS_PRIO_BIT = 6;
    localparam int DSS_WEEK_LSB = 3;
    localparam int DSS_DOW_LSB = 0;
    localparam int DSS_PM_BIT = 5;
    localparam int DSS_H24_BIT = 7;
    localparam logic [2:0] DSS_LAST_WEEK = 3'h7;
    localparam logic [4:0] DSS_DAYS_IN_WEEK = 5'h07;

    // one access from the serial register engine
    typedef struct packed {
        logic wrEn;
        logic rdEn;
        logic [7:0] addr;
        logic [7:0] data;
    } dss_reg_req_t;

    // running calendar, date and time fields bcd as in the clock registers, leapYear a single flag bit
    typedef struct packed {
        logic [7:0] month;
        logic [7:0] date;
        logic [2:0] dayOfWeek;
        logic [7:0] hour;
        logic [7:0] minute;
        logic [7:0] second;
        logic leapYear;
    } dss_cal_t;

    // one schedule as held in four registers
    typedef struct packed {
        logic [7:0] month;
        logic [7:0] weekDay;
        logic [7:0] date;
        logic [7:0] hour;
    } dss_sched_t;

    // hour correction handed to the timekeeper
    typedef struct packed {
        logic load;
        logic [7:0] value;
    } dss_hour_upd_t;
endpackage

/* File: rtl/dss_reg_bank.sv */
// eight byte schedule register bank with registered read data
`timescale 1ns/1ps
`default_nettype none
module dss_reg_bank
    import dss_pkg::*;
(
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic clkEn,
    input wire logic wrEn,
    input wire logic rdEn,
    input wire logic [2:0] index,
    input wire logic [7:0] wrData,
    output logic [7:0] rdData,
    output logic [63:0] contents
);
    logic [7:0] rdSel;

    // one byte per entry, only writable bits ever change
    genvar i;
    generate
        for (i = 0; i < DSS_NUM_REGS; i++)
        begin : g_entry
            localparam logic [7:0] RST_VAL = (i == 4) ? DSS_RST_END_MONTH : DSS_RST_ZERO;
            localparam logic [7:0] MASK = DSS_WR_MASK[8*i +: 8];
            logic [7:0] entry;
            wire hit = wrEn && (index == 3'(i));
            // each byte owns its flop so no slice of contents has two writers
            always_ff @(posedge clk)
            begin
                if (sys_rst)
                    entry <= RST_VAL;
                else if (clkEn && hit)
                    entry <= wrData & MASK;
            end
            assign contents[8*i +: 8] = entry;
        end
    endgenerate

    assign rdSel = contents[8*index +: 8];

    // read data held until the next read so the serial engine can shift it
    always_ff @(posedge clk)
    begin
        if (sys_rst)
            rdData <= DSS_RST_ZERO;
        else if (clkEn && rdEn)
            rdData <= rdSel;
    end
endmodule
`default_nettype wire

/* File: tb/daylight_saving_scheduler_tb_top.sv */
// self-checking bench for the daylight saving scheduler
`timescale 1ns/1ps
`default_nettype none
module daylight_saving_scheduler_tb_top
    import dss_pkg::*;
;
    logic clk;
    logic sysRst;
    logic clkEn;
    dss_reg_req_t regReq;
    logic flagWrEn;
    logic flagWrData;
    dss_cal_t cal;
    logic secTick;
    logic [7:0] rdData;
    dss_hour_upd_t hourUpd;
    logic daylightAdjusted;
    int errTotal;
    int checkCount;
    int cycleCount;
    logic [7:0] maskTable [8];

    dss_scheduler dut (
        .clk(clk),
        .sys_rst(sysRst),
        .clkEn(clkEn),
        .regReq(regReq),
        .flagWrEn(flagWrEn),
        .flagWrData(flagWrData),
        .cal(cal),
        .secTick(secTick),
        .rdData(rdData),
        .hourUpd(hourUpd),
        .daylightAdjusted(daylightAdjusted)
    );

    // 10 MHz clock
    always #50 clk = ~clk;

    // hang guard, whole run needs well under a thousand cycles
    always @(posedge clk)
    begin
        cycleCount <= cycleCount + 1;
        if (cycleCount == 5000)
        begin
            errTotal = errTotal + 1;
            completeRun();
        end
    end

    task automatic completeRun();
        $display("checks %0d mismatches %0d", checkCount, errTotal);
        if (errTotal == 0 && checkCount > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask

    task automatic check(input logic [7:0] got, input logic [7:0] exp, input string what);
        checkCount = checkCount + 1;
        if (got !== exp)
        begin
            errTotal = errTotal + 1;
            $display("wrong value at %0t: %s got %h expected %h", $time, what, got, exp);
        end
    endtask

    // one byte write, strobe held for exactly one taken edge
    task automatic regWrite(input logic [7:0] addr, input logic [7:0] data);
        @(posedge clk);
        regReq <= '{wrEn: 1'b1, rdEn: 1'b0, addr: addr, data: data};
        @(posedge clk);
        regReq.wrEn <= 1'b0;
    endtask

    // read data lands on the taken edge itself, checked just after it
    task automatic regRead(input logic [7:0] addr, input logic [7:0] exp);
        @(posedge clk);
        regReq <= '{wrEn: 1'b0, rdEn: 1'b1, addr: addr, data: 8'h00};
        @(posedge clk);
        regReq.rdEn <= 1'b0;
        #1;
        check(rdData, exp, "read data");
    endtask

    function automatic dss_cal_t mkCal(input logic [7:0] mo, input logic [7:0] dt,
                                       input logic [2:0] dw, input logic [7:0] hr);
        return {mo, dt, dw, hr, 8'h00, 8'h00, 1'b0};
    endfunction

    // present a new second and judge the hour correction that follows
    task automatic secondTick(input dss_cal_t c, input logic expLoad,
                              input logic [7:0] expVal, input logic expFlag);
        @(posedge clk);
        cal <= c;
        secTick <= 1'b1;
        @(posedge clk);
        secTick <= 1'b0;
        #1;
        check({7'h00, hourUpd.load}, {7'h00, expLoad}, "hour load");
        if (expLoad)
            check(hourUpd.value, expVal, "hour value");
        check({7'h00, daylightAdjusted}, {7'h00, expFlag}, "adjusted flag");
    endtask

    // power-up contents of the schedule registers
    task automatic testResetValues();
        for (int i = 0; i < 8; i++)
            regRead(8'h20 + 8'(i), (i == 4) ? 8'h10 : 8'h00);
        check({7'h00, daylightAdjusted}, 8'h00, "flag after reset");
    endtask

    // reserved bits read zero, unmapped address leaves read data alone
    task automatic testMasks();
        for (int i = 0; i < 8; i++)
        begin
            regWrite(8'h20 + 8'(i), 8'hff);
            regRead(8'h20 + 8'(i), maskTable[i]);
        end
        regRead(8'h28, maskTable[7]);
        regWrite(8'h20, 8'h00);
    endtask

    // forward by date in 24-hour mode, then a non-matching date
    task automatic testForwardDate();
        regWrite(8'h21, 8'h00);
        regWrite(8'h22, 8'h08);
        regWrite(8'h23, 8'h02);
        regWrite(8'h20, 8'h83);
        secondTick(mkCal(8'h03, 8'h08, 3'h0, 8'h82), 1'b1, 8'h83, 1'b1);
        secondTick(mkCal(8'h03, 8'h07, 3'h0, 8'h82), 1'b0, 8'h00, 1'b1);
    endtask

    // reverse on the last sunday of october, fired once only
    task automatic testReverseLastWeek();
        regWrite(8'h24, 8'h10);
        regWrite(8'h25, 8'h78);
        regWrite(8'h26, 8'h05);
        regWrite(8'h27, 8'h02);
        secondTick(mkCal(8'h10, 8'h24, 3'h0, 8'h82), 1'b0, 8'h00, 1'b1);
        secondTick(mkCal(8'h10, 8'h31, 3'h0, 8'h82), 1'b1, 8'h81, 1'b0);
        secondTick(mkCal(8'h10, 8'h31, 3'h0, 8'h82), 1'b0, 8'h00, 1'b0);
    endtask

    // clearing the enable clears the flag and stops adjustment
    task automatic testDisable();
        @(posedge clk);
        flagWrEn <= 1'b1;
        flagWrData <= 1'b1;
        @(posedge clk);
        flagWrEn <= 1'b0;
        #1;
        check({7'h00, daylightAdjusted}, 8'h01, "flag written");
        regWrite(8'h20, 8'h03);
        #1;
        check({7'h00, daylightAdjusted}, 8'h00, "flag cleared");
        secondTick(mkCal(8'h03, 8'h08, 3'h0, 8'h82), 1'b0, 8'h00, 1'b0);
    endtask

    // forward by week one, tuesday, stored date ignored
    task automatic testForwardWeekday();
        regWrite(8'h21, 8'h4a);
        regWrite(8'h20, 8'h83);
        secondTick(mkCal(8'h03, 8'h08, 3'h0, 8'h82), 1'b0, 8'h00, 1'b0);
        secondTick(mkCal(8'h03, 8'h05, 3'h2, 8'h82), 1'b1, 8'h83, 1'b1);
    endtask

    // 12-hour mode by date: 11 am forward to 12 pm, 12 pm back to 11 am;
    // a write while the clock enable is low must be lost
    task automatic testTwelveHour();
        regWrite(8'h21, 8'h00);
        regWrite(8'h22, 8'h15);
        regWrite(8'h23, 8'h11);
        regWrite(8'h25, 8'h00);
        regWrite(8'h26, 8'h15);
        regWrite(8'h27, 8'h32);
        regWrite(8'h24, 8'h04);
        regWrite(8'h20, 8'h84);
        @(posedge clk);
        clkEn <= 1'b0;
        regWrite(8'h23, 8'h05);
        clkEn <= 1'b1;
        regRead(8'h23, 8'h11);
        secondTick(mkCal(8'h04, 8'h15, 3'h3, 8'h11), 1'b1, 8'h32, 1'b1);
        secondTick(mkCal(8'h04, 8'h15, 3'h3, 8'h32), 1'b1, 8'h11, 1'b0);
    endtask

    // main sequence; each forward setup writes the enable last, after the other schedule bytes
    initial
    begin
        maskTable = '{8'h9f, 8'h7f, 8'h3f, 8'h3f, 8'h1f, 8'h7f, 8'h3f, 8'h3f};
        clk = 1'b0;
        sysRst = 1'b1;
        clkEn = 1'b1;
        regReq = '0;
        flagWrEn = 1'b0;
        flagWrData = 1'b0;
        cal = mkCal(8'h01, 8'h01, 3'h0, 8'h80);
        secTick = 1'b0;
        errTotal = 0;
        checkCount = 0;
        cycleCount = 0;
        repeat (12) @(posedge clk);
        sysRst <= 1'b0;
        testResetValues();
        testMasks();
        testForwardDate();
        testReverseLastWeek();
        testDisable();
        testForwardWeekday();
        testTwelveHour();
        repeat (4) @(posedge clk);
        completeRun();
    end
endmodule
`default_nettype wire
